// ==== verilog/acss_ctrl.sv ====
// converter channel select and status: register slave, pass sequencer, irq
// assumes a core that converts one channel per request and answers done
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module acss_ctrl (
  // clock, reset, enable
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_ce,
  // register port
  input  wire logic [7:0]                     i_addr,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output var  logic [31:0]                    o_rdata,
  // converter core
  output var  logic                           o_conv_req,
  output var  logic [acss_pkg::ACSS_CH_W-1:0] o_conv_ch,
  input  wire logic                           i_conv_done,
  input  wire logic [acss_pkg::ACSS_RES_W-1:0] i_conv_result,
  // interrupt
  output var  logic                           o_irq
);
  import acss_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  acss_res_if res ();

  logic                start_single_ff;
  logic                start_repeat_ff;
  logic [ACSS_NCH-1:0] smask_ff;
  logic [ACSS_NCH-1:0] rmask_ff;
  logic [1:0]          imask_ff;
  logic [31:0]         nxt_rdata;

  acss_state_e         state_ff;
  logic [ACSS_NCH-1:0] rem_ff;
  logic                rep_mode_ff;
  logic                single_taken_ff;
  logic                pass_begin_ff;
  logic                single_done_ff;
  logic                repeat_done_ff;

  logic [ACSS_NCH-1:0] chan_flags;
  logic [ACSS_NCH-1:0] chan_set;
  logic [ACSS_NCH-1:0] chan_clr;
  logic [1:0]          done_flags;
  logic [1:0]          done_clr;
  logic [1:0]          ev_set;
  logic [1:0]          irq_stat;
  logic [1:0]          irq_clr;

  logic                wr_ctrl;
  logic                wr_stat;
  logic                wr_istat;
  logic [7:0]          rd_off;
  logic                rd_hit;

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign wr_ctrl  = i_wr && (i_addr == ACSS_CTRL_OFS);
  assign wr_stat  = i_wr && (i_addr == ACSS_STAT_OFS);
  assign wr_istat = i_wr && (i_addr == ACSS_ISTAT_OFS);

  // reading window: aligned words from the base, one per channel
  assign rd_off    = i_addr - ACSS_READ_BASE;
  assign rd_hit    = (i_addr >= ACSS_READ_BASE) && (rd_off[1:0] == 2'h0)
                     && (rd_off[7:2] < 6'(ACSS_NCH));
  assign res.rd_ch = rd_off[4:2];

  // ****************************************************************
  // software registers
  // ****************************************************************
  // start bits; a write in the launch cycle wins so a fresh request survives
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      start_single_ff <= 1'b0;
      start_repeat_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_ctrl)
      begin
        start_single_ff <= i_wdata[ACSS_CTRL_SS_BIT];
        start_repeat_ff <= i_wdata[ACSS_CTRL_SR_BIT];
      end
      else if (single_taken_ff)
        start_single_ff <= 1'b0;
    end
  end

  // channel masks; changing smask mid-cycle has no effect on the running pass
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      smask_ff <= ACSS_MASK_RST;
      rmask_ff <= ACSS_MASK_RST;
    end
    else if (i_ce && i_wr)
    begin
      if (i_addr == ACSS_SMASK_OFS)
        smask_ff <= i_wdata[ACSS_NCH-1:0];
      if (i_addr == ACSS_RMASK_OFS)
        rmask_ff <= i_wdata[ACSS_NCH-1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      imask_ff <= 2'h0;
    else if (i_ce && i_wr && (i_addr == ACSS_IMASK_OFS))
      imask_ff <= i_wdata[1:0];
  end

  // ****************************************************************
  // sticky flags
  // ****************************************************************
  // channel flag rises on the very edge that stores the result
  assign chan_set = res.wr ? acss_onehot(res.ch) : '0;
  assign chan_clr = wr_stat ? i_wdata[ACSS_NCH-1:0] : '0;

  // whole-cycle events shared by the done flags and the irq status
  assign ev_set[ACSS_EV_SINGLE]   = single_done_ff;
  assign ev_set[ACSS_EV_REPEAT]   = repeat_done_ff;
  assign done_clr[ACSS_EV_SINGLE] = wr_ctrl && i_wdata[ACSS_CTRL_SD_BIT];
  assign done_clr[ACSS_EV_REPEAT] = (wr_ctrl && i_wdata[ACSS_CTRL_RD_BIT])
                                    || pass_begin_ff;
  assign irq_clr = wr_istat ? i_wdata[1:0] : 2'h0;

  acss_sticky #(.W(ACSS_NCH)) u_chan_flags (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_set   (chan_set),
    .i_clr   (chan_clr),
    .o_q     (chan_flags)
  );

  acss_sticky #(.W(2)) u_done_flags (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_set   (ev_set),
    .i_clr   (done_clr),
    .o_q     (done_flags)
  );

  acss_sticky #(.W(2)) u_irq_stat (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_set   (ev_set),
    .i_clr   (irq_clr),
    .o_q     (irq_stat)
  );

  // ****************************************************************
  // result store
  // ****************************************************************
  acss_store #(.NCH(ACSS_NCH)) u_store (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .res     (res)
  );

  // ****************************************************************
  // pass sequencer
  // ****************************************************************
  // single wins over repeat; the mask is latched so later writes cannot tear it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff    <= ACSS_IDLE;
      rem_ff      <= '0;
      rep_mode_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (state_ff)
        ACSS_IDLE:
          if (start_single_ff && !single_taken_ff)
          begin
            rem_ff      <= smask_ff;
            rep_mode_ff <= 1'b0;
            state_ff    <= ACSS_REQ;
          end
          else if (start_repeat_ff)
          begin
            rem_ff      <= rmask_ff;
            rep_mode_ff <= 1'b1;
            state_ff    <= ACSS_REQ;
          end
        ACSS_REQ:
          state_ff <= (rem_ff == '0) ? ACSS_IDLE : ACSS_WAIT;
        ACSS_WAIT:
          if (i_conv_done)
          begin
            rem_ff   <= rem_ff & ~acss_onehot(o_conv_ch);
            state_ff <= ACSS_REQ;
          end
        default:
          state_ff <= ACSS_IDLE;
      endcase
    end
  end

  // one-cycle events of the sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      single_taken_ff <= 1'b0;
      pass_begin_ff   <= 1'b0;
      single_done_ff  <= 1'b0;
      repeat_done_ff  <= 1'b0;
    end
    else if (i_ce)
    begin
      single_taken_ff <= (state_ff == ACSS_IDLE) && start_single_ff
                         && !single_taken_ff;
      pass_begin_ff   <= (state_ff == ACSS_IDLE) && start_repeat_ff
                         && !(start_single_ff && !single_taken_ff);
      single_done_ff  <= (state_ff == ACSS_REQ) && (rem_ff == '0)
                         && !rep_mode_ff;
      repeat_done_ff  <= (state_ff == ACSS_REQ) && (rem_ff == '0)
                         && rep_mode_ff;
    end
  end

  // core request and result capture; done outside wait is ignored
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_conv_req <= 1'b0;
      o_conv_ch  <= '0;
      res.wr     <= 1'b0;
      res.ch     <= '0;
      res.data   <= ACSS_RES_RST;
    end
    else if (i_ce)
    begin
      o_conv_req <= (state_ff == ACSS_REQ) && (rem_ff != '0);
      if (state_ff == ACSS_REQ)
        o_conv_ch <= acss_first_ch(rem_ff);
      res.wr <= (state_ff == ACSS_WAIT) && i_conv_done;
      if ((state_ff == ACSS_WAIT) && i_conv_done)
      begin
        res.ch   <= o_conv_ch;
        res.data <= i_conv_result;
      end
    end
  end

  // ****************************************************************
  // read data and interrupt
  // ****************************************************************
  // unmapped and reserved bits read zero; data stands one cycle only
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        ACSS_CTRL_OFS:
        begin
          nxt_rdata[ACSS_CTRL_SS_BIT] = start_single_ff;
          nxt_rdata[ACSS_CTRL_SR_BIT] = start_repeat_ff;
          nxt_rdata[ACSS_CTRL_RD_BIT] = done_flags[ACSS_EV_REPEAT];
          nxt_rdata[ACSS_CTRL_SD_BIT] = done_flags[ACSS_EV_SINGLE];
        end
        ACSS_STAT_OFS:  nxt_rdata[ACSS_NCH-1:0] = chan_flags;
        ACSS_SMASK_OFS: nxt_rdata[ACSS_NCH-1:0] = smask_ff;
        ACSS_RMASK_OFS: nxt_rdata[ACSS_NCH-1:0] = rmask_ff;
        ACSS_ISTAT_OFS: nxt_rdata[1:0] = irq_stat;
        ACSS_IMASK_OFS: nxt_rdata[1:0] = imask_ff;
        default:
          if (rd_hit)
            nxt_rdata[ACSS_RES_W-1:0] = res.rd_val;
      endcase
    end
  end

  // whole word captured in one edge, so any access width sees one result
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_ce)
      o_rdata <= nxt_rdata;
  end

  // registered irq trails the status by one cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |(irq_stat & imask_ff);
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  flag_rise_a: assert property ($rose(chan_flags[0]) |-> $past(res.wr && res.ch == 3'h0))
    else $error("channel flag rose without a result write");

  w1c_clear_a: assert property ((i_ce && wr_stat && !res.wr)
    |=> ((chan_flags & $past(i_wdata[ACSS_NCH-1:0])) == 5'h00))
    else $error("written one did not clear channel flag");

  w1c_keep_a: assert property ((i_ce && wr_stat && !res.wr)
    |=> ((chan_flags & ~$past(i_wdata[ACSS_NCH-1:0]))
         == ($past(chan_flags) & ~$past(i_wdata[ACSS_NCH-1:0]))))
    else $error("written zero changed a channel flag");

  single_done_a: assert property ((i_ce && single_done_ff) |=> done_flags[ACSS_EV_SINGLE])
    else $error("single done flag not set at end of cycle");

  repeat_done_a: assert property ((i_ce && repeat_done_ff) |=> done_flags[ACSS_EV_REPEAT])
    else $error("repeat done flag not set at end of pass");

  smask_write_a: assert property ((i_ce && i_wr && i_addr == ACSS_SMASK_OFS)
    |=> smask_ff == $past(i_wdata[ACSS_NCH-1:0]))
    else $error("single mask did not take written value");

  rmask_write_a: assert property ((i_ce && i_wr && i_addr == ACSS_RMASK_OFS)
    |=> rmask_ff == $past(i_wdata[ACSS_NCH-1:0]))
    else $error("repeat mask did not take written value");

  read_upper_a: assert property ((i_ce && i_rd && rd_hit)
    |=> o_rdata[31:ACSS_RES_W] == 22'h0)
    else $error("reading upper bits not zero");

  start_clear_a: assert property ((i_ce && single_taken_ff && !wr_ctrl) |=> !start_single_ff)
    else $error("single start bit did not clear itself");

  repeat_clear_a: assert property ((i_ce && pass_begin_ff && !repeat_done_ff)
    |=> !done_flags[ACSS_EV_REPEAT])
    else $error("repeat done flag survived a new pass");

  flag_with_data_a: assert property ((i_ce && res.wr) |=> chan_flags[$past(res.ch)])
    else $error("flag missing when result stored");

  irq_level_a: assert property ((i_ce && |(irq_stat & imask_ff)) |=> o_irq)
    else $error("unmasked status did not raise irq");

  single_cycle_c: cover property (single_taken_ff ##[1:200] single_done_ff);
  repeat_pass_c:  cover property (pass_begin_ff ##[1:200] repeat_done_ff);
  irq_raise_c:    cover property ($rose(o_irq));
endmodule : acss_ctrl

`default_nettype wire

// ==== verilog/acss_pkg.sv ====
// constants, state codes and helpers for the converter channel select block
// assumes one 25 MHz clock and a synchronous active-low reset everywhere
//
// Functional notes
// - each channel has a done flag that goes to 1 when its conversion ends, else 0.
// - writing a 1 to a done flag clears it and writing a 0 leaves it alone.
// - a single-shot cycle sets the single done flag once all its channels are done.
// - a repeating pass sets the repeat done flag once all its channels are done.
// - the single-shot mask resets to zero and picks the channels of a single cycle.
// - the repeat mask resets to zero and picks the channels of each repeating pass.
// - each channel has a 32-bit reading with the result low and zeros above bit 9.
// - results reset to zero and no software access changes them.
// - the single-shot start bit clears itself once it has launched a cycle.
// - the repeat done flag clears whenever a new repeating pass begins.
`default_nettype none

package acss_pkg;
  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int         ACSS_NCH     = 5;
  localparam int         ACSS_CH_W    = 3;
  localparam int         ACSS_RES_W   = 10;
  localparam logic [4:0] ACSS_MASK_RST = 5'h00;
  localparam logic [9:0] ACSS_RES_RST = 10'h000;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] ACSS_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ACSS_STAT_OFS  = 8'h08;
  localparam logic [7:0] ACSS_SMASK_OFS = 8'h0C;
  localparam logic [7:0] ACSS_RMASK_OFS = 8'h10;
  localparam logic [7:0] ACSS_READ_BASE = 8'h14;
  localparam logic [7:0] ACSS_ISTAT_OFS = 8'h28;
  localparam logic [7:0] ACSS_IMASK_OFS = 8'h2C;

  // control bit positions and event indices
  localparam int ACSS_CTRL_SS_BIT = 1;
  localparam int ACSS_CTRL_SR_BIT = 2;
  localparam int ACSS_CTRL_RD_BIT = 6;
  localparam int ACSS_CTRL_SD_BIT = 7;
  localparam int ACSS_EV_SINGLE   = 0;
  localparam int ACSS_EV_REPEAT   = 1;

  // sequencer states, gray along idle-request-wait-request
  typedef enum logic [1:0]
  {
    ACSS_IDLE = 2'b00,
    ACSS_REQ  = 2'b01,
    ACSS_WAIT = 2'b11
  } acss_state_e;

  // lowest set channel of a mask
  function automatic logic [ACSS_CH_W-1:0] acss_first_ch(input logic [ACSS_NCH-1:0] mask);
    logic [ACSS_CH_W-1:0] idx;
    idx = '0;
    for (int i = ACSS_NCH - 1; i >= 0; i--)
      if (mask[i]) idx = ACSS_CH_W'(i);
    return idx;
  endfunction : acss_first_ch

  // one-hot bit of a channel number
  function automatic logic [ACSS_NCH-1:0] acss_onehot(input logic [ACSS_CH_W-1:0] ch);
    return ACSS_NCH'(1) << ch;
  endfunction : acss_onehot
endpackage : acss_pkg

`default_nettype wire

// ==== verilog/acss_res_if.sv ====
// result write and read-back path between sequencer and result store
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface acss_res_if;
  import acss_pkg::*;
  logic                  wr;
  logic [ACSS_CH_W-1:0]  ch;
  logic [ACSS_RES_W-1:0] data;
  logic [ACSS_CH_W-1:0]  rd_ch;
  logic [ACSS_RES_W-1:0] rd_val;

  modport src (output wr, ch, data, rd_ch, input rd_val);
  modport dst (input wr, ch, data, rd_ch, output rd_val);
endinterface : acss_res_if

`default_nettype wire

// ==== verilog/acss_sticky.sv ====
// sticky flag bank: hardware sets, writer clears
// assumes set and clear are single-cycle terms from the same clock
`timescale 1ns/100ps
`default_nettype none

module acss_sticky #(
  parameter int W = 5
) (
  // clock and control
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // set and clear terms
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  // flags
  output var  logic [W-1:0] o_q
);
  // set wins over clear so an event in the clearing cycle is kept
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_q <= '0;
    else if (i_ce)
      o_q <= (o_q & ~i_clr) | i_set;
  end
endmodule : acss_sticky

`default_nettype wire

// ==== verilog/acss_store.sv ====
// channel result array with combinational read-back
// assumes the writer never gives a channel number at or above NCH
`timescale 1ns/100ps
`default_nettype none

module acss_store
  import acss_pkg::*;
#(
  parameter int NCH = acss_pkg::ACSS_NCH
) (
  // clock and control
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // write and read path
  acss_res_if.dst   res
);
  logic [ACSS_RES_W-1:0] mem_ff [NCH];

  // only the sequencer writes; the bus has no path in here
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      for (int i = 0; i < NCH; i++) mem_ff[i] <= ACSS_RES_RST;
    else if (i_ce && res.wr)
      mem_ff[res.ch] <= res.data;
  end

  // out-of-range index reads zero rather than x
  assign res.rd_val = (res.rd_ch < ACSS_CH_W'(NCH)) ? mem_ff[res.rd_ch] : '0;

  hold_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!res.wr || !i_ce) |=> $stable(mem_ff[0]))
    else $error("result changed without a conversion write");
endmodule : acss_store

`default_nettype wire

// ==== test/acss_core_model.sv ====
// behavioural converter core: one channel per request, answered after a set delay
// assumes one outstanding request at a time, all on the 25 MHz clock
`timescale 1ns/100ps
`default_nettype none

module acss_core_model
  import acss_pkg::*;
(
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  // bench knobs
  input  wire logic [7:0]                      i_delay,
  input  wire logic [acss_pkg::ACSS_RES_W-1:0] i_base,
  // request side
  input  wire logic                            i_req,
  input  wire logic [acss_pkg::ACSS_CH_W-1:0]  i_ch,
  // answer side
  output var  logic                            o_done,
  output var  logic [acss_pkg::ACSS_RES_W-1:0] o_result
);
  logic                 busy_ff;
  logic [7:0]           cnt_ff;
  logic [ACSS_CH_W-1:0] ch_ff;

  // result lines toggle outside the done cycle, so a late sample never looks valid
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 8'h00;
      ch_ff    <= '0;
      o_done   <= 1'b0;
      o_result <= 10'h000;
    end
    else if (i_req)
    begin
      busy_ff  <= 1'b1;
      cnt_ff   <= i_delay;
      ch_ff    <= i_ch;
      o_done   <= 1'b0;
      o_result <= ~o_result;
    end
    else if (busy_ff && cnt_ff == 8'h00)
    begin
      busy_ff  <= 1'b0;
      o_done   <= 1'b1;
      o_result <= i_base ^ {ch_ff, ch_ff, ch_ff, 1'b1};
    end
    else
    begin
      cnt_ff   <= cnt_ff - 8'h01;
      o_done   <= 1'b0;
      o_result <= ~o_result;
    end
  end
endmodule : acss_core_model

`default_nettype wire

// ==== test/adc_channel_select_status_tb.sv ====
// self-checking bench for the converter channel select and status block
// assumes acss_ctrl beside the behavioural core model, one 25 MHz clock
`timescale 1ns/100ps
`default_nettype none

module adc_channel_select_status_tb;
  import acss_pkg::*;
  logic                  i_clk;
  logic                  i_rst_n;
  logic [7:0]            i_addr;
  logic [31:0]           i_wdata;
  logic                  i_wr;
  logic                  i_rd;
  logic [31:0]           o_rdata;
  logic                  o_conv_req;
  logic [ACSS_CH_W-1:0]  o_conv_ch;
  logic                  i_conv_done;
  logic [ACSS_RES_W-1:0] i_conv_result;
  logic                  o_irq;
  logic [7:0]            delay;
  logic [ACSS_RES_W-1:0] base;
  logic                  ce;
  int                    err_total;
  int                    total_checks;

  // ****************************************************************
  // design and core model
  // ****************************************************************
  acss_ctrl u_acss_ctrl (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_req(o_conv_req), .o_conv_ch(o_conv_ch),
    .i_conv_done(i_conv_done), .i_conv_result(i_conv_result), .o_irq(o_irq)
  );

  acss_core_model u_acss_core_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_delay(delay), .i_base(base),
    .i_req(o_conv_req), .i_ch(o_conv_ch), .o_done(i_conv_done), .o_result(i_conv_result)
  );

  // ****************************************************************
  // clock, tasks and helpers
  // ****************************************************************
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // always one whole-word read, so a result can never tear
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rdchk

  // bounded wait for the interrupt line to reach a level; skips the register lag first
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    repeat (2) @(posedge i_clk);
    while (o_irq !== lvl && n < 3000)
    begin
      @(posedge i_clk);
      n++;
    end
    chk({31'h0, o_irq}, {31'h0, lvl});
  endtask : wait_irq

  // result the core model hands back for a channel
  function automatic logic [31:0] exp_res(input logic [9:0] s, input int ch);
    logic [2:0] c;
    c = 3'(ch);
    return {22'h0, s ^ {c, c, c, 1'b1}};
  endfunction : exp_res

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    final_report();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    err_total    = 0;
    total_checks = 0;
    i_rst_n      = 1'b0;
    i_addr       = 8'h00;
    i_wdata      = 32'h0;
    i_wr         = 1'b0;
    i_rd         = 1'b0;
    delay        = 8'h00;
    base         = 10'h000;
    ce           = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 'h30; a += 4)
      rdchk(8'(a), 32'h0);
    $display("test reset_values done");
    // masks keep five bits; readings and holes ignore writes
    wr(ACSS_SMASK_OFS, 32'hFFFF_FFFF);
    wr(ACSS_RMASK_OFS, 32'hFFFF_FFFF);
    wr(8'h14, 32'hFFFF_FFFF);
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(ACSS_SMASK_OFS, 32'h1F);
    rdchk(ACSS_RMASK_OFS, 32'h1F);
    rdchk(8'h14, 32'h0);
    rdchk(8'h30, 32'h0);
    rdchk(8'h0D, 32'h0);
    // a write while the clock enable is low must be dropped
    @(posedge i_clk);
    ce <= 1'b0;
    wr(ACSS_SMASK_OFS, 32'h03);
    ce <= 1'b1;
    rdchk(ACSS_SMASK_OFS, 32'h1F);
    $display("test register_access done");
    // single shot on channels 0, 2, 4; the mask is left alone while it runs
    base  <= 10'h155;
    delay <= 8'h00;
    wr(ACSS_SMASK_OFS, 32'h15);
    wr(ACSS_IMASK_OFS, 32'h1);
    wr(ACSS_CTRL_OFS, 32'h2);
    wait_irq(1'b1);
    rdchk(ACSS_CTRL_OFS, 32'h80);
    rdchk(ACSS_STAT_OFS, 32'h15);
    rdchk(ACSS_ISTAT_OFS, 32'h1);
    for (int c = 0; c < ACSS_NCH; c++)
      rdchk(8'(ACSS_READ_BASE + 4 * c), (c % 2 == 0) ? exp_res(10'h155, c) : 32'h0);
    // interrupt masked, unmasked, then flags cleared, channel 0 first and the other two at once
    wr(ACSS_IMASK_OFS, 32'h0);
    wait_irq(1'b0);
    wr(ACSS_IMASK_OFS, 32'h1);
    wait_irq(1'b1);
    wr(ACSS_STAT_OFS, 32'h0);
    rdchk(ACSS_STAT_OFS, 32'h15);
    wr(ACSS_STAT_OFS, 32'h1);
    rdchk(ACSS_STAT_OFS, 32'h14);
    wr(ACSS_STAT_OFS, 32'h1F);
    rdchk(ACSS_STAT_OFS, 32'h0);
    wr(ACSS_CTRL_OFS, 32'h80);
    rdchk(ACSS_CTRL_OFS, 32'h0);
    wr(ACSS_ISTAT_OFS, 32'h1);
    wait_irq(1'b0);
    $display("test single_shot done");
    // repeating passes on channels 1 and 3 with a slow core
    base  <= 10'h2CA;
    delay <= 8'h14;
    wr(ACSS_RMASK_OFS, 32'h0A);
    wr(ACSS_IMASK_OFS, 32'h2);
    wr(ACSS_CTRL_OFS, 32'h4);
    wait_irq(1'b1);
    rdchk(ACSS_CTRL_OFS, 32'h4);
    rdchk(ACSS_STAT_OFS, 32'h0A);
    rdchk(8'h18, exp_res(10'h2CA, 1));
    rdchk(8'h20, exp_res(10'h2CA, 3));
    // stop repeating: the pass in flight still completes and leaves its flag
    wr(ACSS_CTRL_OFS, 32'h0);
    wr(ACSS_ISTAT_OFS, 32'h2);
    wait_irq(1'b1);
    rdchk(ACSS_CTRL_OFS, 32'h40);
    $display("test repeat done");
    final_report();
  end
endmodule : adc_channel_select_status_tb

`default_nettype wire
